// *** vcarb_regs.svh ***
// Offsets, field positions, reset values for the VC arbitration config bank
`ifndef VCARB_REGS_SVH
`define VCARB_REGS_SVH

`define VCARB_ADDR_W 12
`define VCARB_OFF_PORT_VC_CONTROL 12'h20c
`define VCARB_OFF_PORT_VC_STATUS 12'h20e
`define VCARB_OFF_VC0_RES_CAP 12'h210
`define VCARB_OFF_VC0_RES_CTL 12'h214

`define VCARB_LOAD_VC_ARB_TABLE_BIT 0
`define VCARB_VC_ARB_SEL_LSB 1
`define VCARB_VC_ARB_SEL_MSB 3
`define VCARB_STATUS_LSB 16
`define VCARB_TABLE_COHERENT_BIT 16
`define VCARB_PORT_ARB_CAP_LSB 0
`define VCARB_PORT_ARB_CAP_MSB 7
`define VCARB_ADV_PKT_SW_BIT 14
`define VCARB_REJECT_SNOOP_BIT 15
`define VCARB_MAX_TS_LSB 16
`define VCARB_MAX_TS_MSB 22
`define VCARB_TABLE_OFF_LSB 24
`define VCARB_TABLE_OFF_MSB 31
`define VCARB_TC_MAP_LSB 0
`define VCARB_TC_MAP_MSB 7
`define VCARB_LOAD_PORT_ARB_BIT 16

`define VCARB_RST_VC_ARB_SEL 3'h0
`define VCARB_RST_TABLE_COHERENT 1'h0
`define VCARB_RST_PORT_ARB_CAP 8'h01
`define VCARB_RST_TABLE_OFF 8'h00
`define VCARB_RST_TC_MAP 8'hff
`define VCARB_VC_ARB_CAP 8'h00
`define VCARB_MAX_TIME_SLOTS 7'h00
`define VCARB_SCHEME_FIXED_RR 3'h0

`endif

// *** vcarb_pkg.sv ***
// Types shared by the VC arbitration config bank
package vcarb_pkg;

    // Gray order along idle -> waiting for load done
    typedef enum logic [1:0] {
        VCARB_LOAD_IDLE = 2'b00,
        VCARB_LOAD_WAIT = 2'b01
    } vcarb_load_state_t;

    typedef logic [2:0] vcarb_scheme_t;

endpackage : vcarb_pkg

// *** vcarb_load_if.sv ***
// Carrier between the register bank and its table load tracker
`timescale 1ns/1ps
interface vcarb_load_if;
    logic loadReq;
    logic usesTable;
    logic tableEntryWrite;
    logic loadDone;
    logic loadPulse;
    logic pending;

    modport bank (
        output loadReq, usesTable, tableEntryWrite, loadDone,
        input loadPulse, pending
    );
    modport tracker (
        input loadReq, usesTable, tableEntryWrite, loadDone,
        output loadPulse, pending
    );
endinterface : vcarb_load_if

// *** vcarb_load_ctl.sv ***
// Port arbitration table load request and pending status tracker
`timescale 1ns/1ps
module vcarb_load_ctl (
    input wire logic core_clk, // core clock
    input wire logic rstn, // async reset, active low
    vcarb_load_if.tracker lif // bank side
);
    import vcarb_pkg::*;

    vcarb_load_state_t state_q;

    ////////////////////////////////////////////////////////////////////
    // load on write one
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= VCARB_LOAD_IDLE;
            lif.loadPulse <= 1'b0;
        end else begin
            lif.loadPulse <= 1'b0;
            case (state_q)
                VCARB_LOAD_IDLE: begin
                    if (lif.loadReq && lif.usesTable) begin
                        lif.loadPulse <= 1'b1;
                        state_q <= VCARB_LOAD_WAIT;
                    end
                end
                VCARB_LOAD_WAIT: begin
                    if (lif.loadDone) begin
                        state_q <= VCARB_LOAD_IDLE;
                    end
                end
                default: begin
                    state_q <= VCARB_LOAD_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pending set wins clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lif.pending <= 1'b0;
        end else if (lif.tableEntryWrite) begin
            lif.pending <= 1'b1;
        end else if (state_q == VCARB_LOAD_WAIT && lif.loadDone) begin
            lif.pending <= 1'b0;
        end
    end

endmodule : vcarb_load_ctl

// *** vcarb_config_regs.sv ***
// Virtual channel arbitration configuration register bank
`timescale 1ns/1ps
`include "vcarb_regs.svh"

// Function
// - The load-VC-arbitration-table bit reads zero and does nothing.
// - A three-bit VC arbitration scheme selector is read-write, reset 0.
// - A read-only table-coherent status bit resets to zero.
// - The port arbitration capability byte is loadable, reset 0x01.
// - The advanced packet switching bit always reads zero.
// - The reject snoop bit always reads zero.
// - The seven-bit maximum time slots field always reads zero.
// - The port arbitration table offset byte is loadable, reset zero.
// - The TC to VC map resets to 0xff with bit 0 fixed, bits 1-7 writable.
// - Writing one to the load bit reloads port arbitration; zero is inert.
// - A load request counts only when the selected scheme uses the table and no earlier load is still waiting for load done.
// - The load-port-arbitration-table bit always reads zero.
// - Pending sets on any table entry write and clears when a load finishes with no entry write in that same cycle.
// - The VC arbitration capability reports zero.
module vcarb_config_regs (
    input wire logic core_clk, // 250 MHz core clock
    input wire logic rstn, // async reset, active low
    input wire logic cfgWrEn, // config write strobe
    input wire logic cfgRdEn, // config read strobe
    input wire logic [`VCARB_ADDR_W-1:0] cfgAddr, // config byte address
    input wire logic [3:0] cfgByteEn, // config byte enables
    input wire logic [31:0] cfgWrData, // config write data
    input wire logic loadableWrEn, // permits writes to loadable fields
    input wire vcarb_pkg::vcarb_scheme_t portArbSchemeSelect, // from ctl
    input wire logic tableEntryWrite, // a table entry was written
    input wire logic loadDone, // arbitration logic finished loading
    output logic [31:0] cfgRdData, // config read data
    output logic cfgRdValid, // read data valid pulse
    output vcarb_pkg::vcarb_scheme_t vcArbSchemeSelect, // VC arb scheme
    output logic [7:0] vcArbCapability, // VC arb capability
    output logic [7:0] portArbCapability, // port arb capability
    output logic [7:0] portArbTableOffset, // table offset, 16 byte units
    output logic [7:0] tcToVcMap, // TC to VC map
    output logic loadPortArbTable, // reload pulse to arbitration
    output logic portArbTablePending // table pending status
);
    import vcarb_pkg::*;

    function automatic logic hitDword(
        input logic [`VCARB_ADDR_W-1:0] addr,
        input logic [`VCARB_ADDR_W-1:0] off
    );
        hitDword = (addr[`VCARB_ADDR_W-1:2] == off[`VCARB_ADDR_W-1:2]);
    endfunction : hitDword

    vcarb_load_if lif ();

    logic wrCtl;
    logic wrCap;
    logic wrResCtl;
    logic atPortVc;
    logic atCap;
    logic atResCtl;
    logic wrSelByte;
    logic wrCapByte;
    logic wrOffByte;
    logic wrMapByte;
    logic wrLoadByte;
    logic tableCoherent_q;
    logic [31:0] rdMux;

    // Dword decode shared by the write strobes and the read mux
    assign atPortVc = hitDword(cfgAddr, `VCARB_OFF_PORT_VC_CONTROL);
    assign atCap = hitDword(cfgAddr, `VCARB_OFF_VC0_RES_CAP);
    assign atResCtl = hitDword(cfgAddr, `VCARB_OFF_VC0_RES_CTL);

    assign wrCtl = cfgWrEn && atPortVc;
    assign wrCap = cfgWrEn && atCap;
    assign wrResCtl = cfgWrEn && atResCtl;

    // Per-byte strobes: a field moves only when its own byte is enabled
    assign wrSelByte = wrCtl && cfgByteEn[0];
    assign wrCapByte = wrCap && loadableWrEn && cfgByteEn[0];
    assign wrOffByte = wrCap && loadableWrEn && cfgByteEn[3];
    assign wrMapByte = wrResCtl && cfgByteEn[0];
    assign wrLoadByte = wrResCtl && cfgByteEn[2];

    ////////////////////////////////////////////////////////////////////
    // VC arbitration scheme selector
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            vcArbSchemeSelect <= `VCARB_RST_VC_ARB_SEL;
        end else if (wrSelByte) begin
            vcArbSchemeSelect <=
                cfgWrData[`VCARB_VC_ARB_SEL_MSB:`VCARB_VC_ARB_SEL_LSB];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            vcArbCapability <= `VCARB_VC_ARB_CAP;
        end else begin
            vcArbCapability <= `VCARB_VC_ARB_CAP;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Loadable fields only move while the load path is opened, so normal
    // software cannot rewrite what the platform advertised.
    // loadable capability byte
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            portArbCapability <= `VCARB_RST_PORT_ARB_CAP;
        end else if (wrCapByte) begin
            portArbCapability <=
                cfgWrData[`VCARB_PORT_ARB_CAP_MSB:`VCARB_PORT_ARB_CAP_LSB];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            portArbTableOffset <= `VCARB_RST_TABLE_OFF;
        end else if (wrOffByte) begin
            portArbTableOffset <=
                cfgWrData[`VCARB_TABLE_OFF_MSB:`VCARB_TABLE_OFF_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // TC map, bit 0 fixed
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tcToVcMap <= `VCARB_RST_TC_MAP;
        end else if (wrMapByte) begin
            tcToVcMap <= {cfgWrData[`VCARB_TC_MAP_MSB:`VCARB_TC_MAP_LSB+1],
                          tcToVcMap[0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write one requests load
    // The bit is never stored: it only launches a request, so a zero
    // written here is inert and a read of it always sees zero.
    assign lif.loadReq = wrLoadByte && cfgWrData[`VCARB_LOAD_PORT_ARB_BIT];
    // fixed round robin has no table
    assign lif.usesTable = (portArbSchemeSelect != `VCARB_SCHEME_FIXED_RR);
    assign lif.tableEntryWrite = tableEntryWrite;
    assign lif.loadDone = loadDone;

    // Tracker owns the reload pulse and the pending flag, so both leave
    // this block straight from flops.
    vcarb_load_ctl u_load (
        .core_clk(core_clk),
        .rstn(rstn),
        .lif(lif)
    );

    assign loadPortArbTable = lif.loadPulse;
    assign portArbTablePending = lif.pending;

    ////////////////////////////////////////////////////////////////////
    // coherent status flop
    // With no VC table behind it the bit has nothing to track, so it
    // stays at its reset value; a later table only needs a next value.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tableCoherent_q <= `VCARB_RST_TABLE_COHERENT;
        end else begin
            tableCoherent_q <= `VCARB_RST_TABLE_COHERENT;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path; unmapped dwords and reserved bits read zero
    // A read that meets a write in one cycle returns the old contents,
    // since the mux looks at the flops before that edge.
    always_comb begin
        rdMux = 32'h0;
        if (atPortVc) begin
            rdMux[`VCARB_VC_ARB_SEL_MSB:`VCARB_VC_ARB_SEL_LSB] =
                vcArbSchemeSelect;
            rdMux[`VCARB_LOAD_VC_ARB_TABLE_BIT] = 1'b0;
            rdMux[`VCARB_TABLE_COHERENT_BIT] = tableCoherent_q;
        end else if (atCap) begin
            rdMux[`VCARB_PORT_ARB_CAP_MSB:`VCARB_PORT_ARB_CAP_LSB] =
                portArbCapability;
            rdMux[`VCARB_ADV_PKT_SW_BIT] = 1'b0;
            rdMux[`VCARB_REJECT_SNOOP_BIT] = 1'b0;
            rdMux[`VCARB_MAX_TS_MSB:`VCARB_MAX_TS_LSB] =
                `VCARB_MAX_TIME_SLOTS;
            rdMux[`VCARB_TABLE_OFF_MSB:`VCARB_TABLE_OFF_LSB] =
                portArbTableOffset;
        end else if (atResCtl) begin
            rdMux[`VCARB_TC_MAP_MSB:`VCARB_TC_MAP_LSB] = tcToVcMap;
            rdMux[`VCARB_LOAD_PORT_ARB_BIT] = 1'b0;
        end
    end

    // reserved bits zero
    // Data holds until the next read so a slow master may take it late
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfgRdData <= 32'h0;
        end else if (cfgRdEn) begin
            cfgRdData <= rdMux;
        end
    end

    // Valid trails the read strobe by exactly one cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfgRdValid <= 1'b0;
        end else begin
            cfgRdValid <= cfgRdEn;
        end
    end

endmodule : vcarb_config_regs

// *** vcarb_config_regs_sva.sv ***
// Port-level assertions for the VC arbitration config bank
`timescale 1ns/1ps
module vcarb_regs_sva (
    input wire logic core_clk, // clock
    input wire logic rstn, // reset
    input wire logic cfgWrEn, // write strobe
    input wire logic [11:0] cfgAddr, // address
    input wire logic [3:0] cfgByteEn, // byte enables
    input wire logic [31:0] cfgWrData, // write data
    input wire vcarb_pkg::vcarb_scheme_t portArbSchemeSelect, // scheme
    input wire logic tableEntryWrite, // entry written
    input wire logic loadDone, // load finished
    input wire logic [31:0] cfgRdData, // read data
    input wire logic cfgRdValid, // read valid
    input wire vcarb_pkg::vcarb_scheme_t vcArbSchemeSelect, // VC scheme
    input wire logic [7:0] vcArbCapability, // VC capability
    input wire logic [7:0] tcToVcMap, // TC map
    input wire logic loadPortArbTable, // reload pulse
    input wire logic portArbTablePending // pending
);
    import vcarb_pkg::*;
    wire atPvc = cfgAddr[11:2] == 10'h83;
    wire atCtl = cfgAddr[11:2] == 10'h85;
    wire selWr = cfgWrEn && cfgByteEn[0] && atPvc;
    // Scheme zero has no table, so a load there is meaningless
    wire loadOk = cfgWrEn && cfgByteEn[2] && cfgWrData[16] && atCtl
        && portArbSchemeSelect != 3'h0;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_load_done;
        loadPortArbTable ##1 (loadDone && !tableEntryWrite);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_pvc_fixed_bits: assert property (
        cfgRdValid && $past(atPvc) |-> cfgRdData[31:4] == 28'h0
        && !cfgRdData[0]) else $error("port VC dword fixed bits set");
    a_load_reads_zero: assert property (
        cfgRdValid && $past(atCtl) |-> !cfgRdData[16])
        else $error("load bit read back as one");
    a_vc_cap_zero: assert property (vcArbCapability == 8'h00)
        else $error("VC capability not zero");
    a_tc_bit_fixed: assert property (tcToVcMap[0])
        else $error("TC map bit 0 cleared");
    a_sel_by_write: assert property (
        !$stable(vcArbSchemeSelect) |-> $past(selWr))
        else $error("VC scheme changed without a write");
    a_load_has_cause: assert property (
        loadPortArbTable |-> $past(loadOk))
        else $error("reload pulse without a valid load write");
    a_load_one_cycle: assert property (
        loadPortArbTable |=> !loadPortArbTable)
        else $error("reload pulse longer than one cycle");
    a_pend_set: assert property (
        tableEntryWrite |=> portArbTablePending)
        else $error("pending not set by entry write");
    a_pend_clear: assert property (
        s_load_done |=> !portArbTablePending)
        else $error("pending not cleared after load");
endmodule : vcarb_regs_sva

bind vcarb_config_regs vcarb_regs_sva u_sva (.core_clk(core_clk),
    .rstn(rstn), .cfgWrEn(cfgWrEn), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .portArbSchemeSelect(portArbSchemeSelect),
    .tableEntryWrite(tableEntryWrite), .loadDone(loadDone),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
    .vcArbSchemeSelect(vcArbSchemeSelect),
    .vcArbCapability(vcArbCapability), .tcToVcMap(tcToVcMap),
    .loadPortArbTable(loadPortArbTable),
    .portArbTablePending(portArbTablePending));

// *** testbench.sv ***
// Self-checking bench for the VC arbitration config bank
`timescale 1ns/1ps
module testbench;
    import vcarb_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic cfgWrEn = 1'b0, cfgRdEn = 1'b0, loadableWrEn = 1'b0;
    logic tableEntryWrite = 1'b0, loadDone = 1'b0;
    logic [11:0] cfgAddr = 12'h000;
    logic [3:0] cfgByteEn = 4'h0;
    logic [31:0] cfgWrData = 32'h0, cfgRdData;
    vcarb_scheme_t portArbSchemeSelect = 3'h0, vcArbSchemeSelect;
    logic [7:0] vcArbCapability, portArbCapability, portArbTableOffset;
    logic [7:0] tcToVcMap;
    logic cfgRdValid, loadPortArbTable, portArbTablePending, pulseSeen;
    int failCount = 0, nChecks = 0, cycles = 0;
    always #2 core_clk = ~core_clk;
    vcarb_config_regs dut (.core_clk(core_clk), .rstn(rstn),
        .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
        .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
        .loadableWrEn(loadableWrEn),
        .portArbSchemeSelect(portArbSchemeSelect),
        .tableEntryWrite(tableEntryWrite), .loadDone(loadDone),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
        .vcArbSchemeSelect(vcArbSchemeSelect),
        .vcArbCapability(vcArbCapability),
        .portArbCapability(portArbCapability),
        .portArbTableOffset(portArbTableOffset), .tcToVcMap(tcToVcMap),
        .loadPortArbTable(loadPortArbTable),
        .portArbTablePending(portArbTablePending));
    task automatic giveVerdict();
        if (failCount == 0 && nChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : giveVerdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Write, then note whether it launched a reload pulse
    task automatic wr(input logic [11:0] a, input logic [3:0] be,
        input logic [31:0] d);
        @(posedge core_clk);
        cfgWrEn <= 1'b1;
        cfgAddr <= a;
        cfgByteEn <= be;
        cfgWrData <= d;
        @(posedge core_clk);
        cfgWrEn <= 1'b0;
        #1 pulseSeen = loadPortArbTable;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        cfgRdEn <= 1'b1;
        cfgAddr <= a;
        @(posedge core_clk);
        cfgRdEn <= 1'b0;
        #1 chk(cfgRdValid ? cfgRdData : 32'hdeadbeef, exp);
    endtask : rd
    task automatic pulse(input bit done);
        @(posedge core_clk);
        if (done) loadDone <= 1'b1;
        else tableEntryWrite <= 1'b1;
        @(posedge core_clk);
        loadDone <= 1'b0;
        tableEntryWrite <= 1'b0;
        #1;
    endtask : pulse
    // Guards against a hang in any handshake
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            giveVerdict();
        end
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        rd(12'h20c, 32'h0);
        rd(12'h210, 32'h1);
        rd(12'h214, 32'hff);
        chk(tcToVcMap, 32'hff);
        wr(12'h20c, 4'hf, 32'hffffffff);
        rd(12'h20c, 32'he);
        wr(12'h20c, 4'he, 32'h0);
        rd(12'h20c, 32'he);
        wr(12'h20c, 4'h1, 32'h4);
        rd(12'h20c, 32'h4);
        chk(vcArbSchemeSelect, 32'h2);
        chk(vcArbCapability, 32'h0);
        wr(12'h210, 4'hf, 32'hffffffff);
        rd(12'h210, 32'h1);
        @(posedge core_clk) loadableWrEn <= 1'b1;
        wr(12'h210, 4'hf, 32'hffffffff);
        rd(12'h210, 32'hff0000ff);
        wr(12'h210, 4'h7, 32'h3);
        rd(12'h210, 32'hff000003);
        chk(portArbCapability, 32'h3);
        chk(portArbTableOffset, 32'hff);
        wr(12'h214, 4'hf, 32'h0000ff5a);
        rd(12'h214, 32'h5b);
        chk(tcToVcMap, 32'h5b);
        wr(12'h218, 4'hf, 32'hffffffff);
        rd(12'h218, 32'h0);
        pulse(0);
        chk(portArbTablePending, 1);
        wr(12'h214, 4'h4, 32'h10000);
        chk(pulseSeen, 0);
        @(posedge core_clk) portArbSchemeSelect <= 3'h1;
        wr(12'h214, 4'h4, 32'h10000);
        chk(pulseSeen, 1);
        pulse(1);
        chk(portArbTablePending, 0);
        pulse(0);
        wr(12'h214, 4'h4, 32'h10000);
        chk(pulseSeen, 1);
        wr(12'h214, 4'h4, 32'h10000);
        chk(pulseSeen, 0);
        chk(portArbTablePending, 1);
        pulse(1);
        chk(portArbTablePending, 0);
        wr(12'h214, 4'h4, 32'h0);
        chk(pulseSeen, 0);
        rd(12'h214, 32'h5b);
        giveVerdict();
    end
endmodule : testbench
